// *** src/lsw_pkg.sv ***
// Constants, state codes and carrier types for the load switch supervisor.
// Assumes one 25 MHz clock; the millisecond time base restarts on each state change.
package lsw_pkg;

    localparam int CLK_PERIOD_NS = 40;
    localparam int TICK_MS       = 1;
    localparam int TICK_CYC      = TICK_MS * 1000000 / CLK_PERIOD_NS;
    localparam int MASK_MIN_MS   = 14;
    localparam int MASK_MS       = 37;
    localparam int RETRY_RATIO   = 15;
    localparam int CNT_W         = 10;
    localparam int PRE_W         = 16;

    typedef enum logic [2:0] {
        ST_OFF     = 3'h0,
        ST_ON      = 3'h1,
        ST_MASK    = 3'h2,
        ST_WAIT    = 3'h3,
        ST_LATCHED = 3'h4,
        ST_THERMAL = 3'h5
    } sup_state_e;

    typedef struct packed {
        logic enable;
        logic ilim_fwd;
        logic ilim_rev;
        logic over_temp;
        logic temp_cooled;
    } sense_s;

endpackage

// *** src/load_switch_fault_supervisor.sv ***
// Fault supervisor: blanking, latch-off or autoretry, thermal shutdown.
// Assumes all sense inputs and enable are asynchronous pins.
`timescale 1ns/100ps
module load_switch_fault_supervisor
    import lsw_pkg::*;
#(
    parameter int         TICK_CYCLES = TICK_CYC,
    parameter int         MASK_TICKS  = MASK_MS,
    parameter int         WAIT_RATIO  = RETRY_RATIO,
    parameter logic       AUTORETRY   = 1'b1
) (
    input  wire logic   clk,
    input  wire logic   srst,
    input  wire sense_s sense,
    output logic        switch_on,
    output logic        fault_n_data,
    output logic        fault_n_oe
);

    localparam int WAIT_TICKS = MASK_TICKS * WAIT_RATIO;

    // Refuse a mask interval under its minimum, and settings the fixed-width counters cannot hold
    if (MASK_TICKS * TICK_MS < MASK_MIN_MS) begin
        $error("fault_mask_interval below its minimum");
    end
    if (TICK_CYCLES < 2 || TICK_CYCLES >= (1 << PRE_W)) begin
        $error("TICK_CYCLES out of range");
    end
    if (MASK_TICKS < 1 || WAIT_TICKS >= (1 << CNT_W)) begin
        $error("interval counts out of range");
    end

    // Two-stage synchroniser; first stage read only by second
    sense_s meta_q;
    sense_s sync_q;

    always_ff @(posedge clk) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= sense;
            sync_q <= meta_q;
        end
    end

    logic en_s;
    logic ilim_s;
    logic hot_s;
    logic cool_s;

    assign en_s   = sync_q.enable;
    assign ilim_s = sync_q.ilim_fwd | sync_q.ilim_rev;
    assign hot_s  = sync_q.over_temp;
    assign cool_s = sync_q.temp_cooled;

    sup_state_e       state_q;
    sup_state_e       state_d;
    logic [PRE_W-1:0] pre_q;
    logic [CNT_W-1:0] cnt_q;
    logic             tick;
    logic             restart;

    function automatic logic expired(input logic [CNT_W-1:0] cnt,
                                     input int               lim);
        expired = (cnt == CNT_W'(lim - 1));
    endfunction

    // Prescaler restarts with each interval so the first tick is full
    assign tick    = (pre_q == PRE_W'(TICK_CYCLES - 1));
    assign restart = (state_d != state_q);

    always_ff @(posedge clk) begin
        if (srst || restart) begin
            pre_q <= '0;
        end else if (tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + PRE_W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst || restart) begin
            cnt_q <= '0;
        end else if (tick) begin
            cnt_q <= cnt_q + CNT_W'(1);
        end
    end

    always_comb begin
        state_d = state_q;
        if (!en_s) begin
            state_d = ST_OFF;
        end else if (hot_s && state_q != ST_LATCHED) begin
            state_d = ST_THERMAL;
        end else begin
            case (state_q)
                ST_OFF: begin
                    state_d = ST_ON;
                end
                ST_ON: begin
                    if (ilim_s) begin
                        state_d = ST_MASK;
                    end
                end
                ST_MASK: begin
                    if (!ilim_s) begin
                        state_d = ST_ON;
                    end else if (tick && expired(cnt_q, MASK_TICKS)) begin
                        state_d = AUTORETRY ? ST_WAIT : ST_LATCHED;
                    end
                end
                ST_WAIT: begin
                    if (tick && expired(cnt_q, WAIT_TICKS)) begin
                        state_d = ST_ON;
                    end
                end
                ST_LATCHED: begin
                    state_d = ST_LATCHED;
                end
                ST_THERMAL: begin
                    if (AUTORETRY && cool_s) begin
                        state_d = ST_ON;
                    end
                end
                default: begin
                    state_d = ST_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    // Outputs follow the next state so a trip shows on the same edge
    always_ff @(posedge clk) begin
        if (srst) begin
            switch_on  <= 1'b0;
            fault_n_oe <= 1'b0;
        end else begin
            switch_on  <= (state_d == ST_ON) || (state_d == ST_MASK);
            fault_n_oe <= (state_d == ST_WAIT) || (state_d == ST_LATCHED)
                          || (state_d == ST_THERMAL);
        end
    end

    // Open drain: only ever pulls low
    always_ff @(posedge clk) begin
        if (srst) begin
            fault_n_data <= 1'b0;
        end else begin
            fault_n_data <= 1'b0;
        end
    end

    // Cycles spent in blanking, for the length check
    logic [31:0] mask_cyc_q;

    always_ff @(posedge clk) begin
        if (srst || state_q != ST_MASK) begin
            mask_cyc_q <= '0;
        end else begin
            mask_cyc_q <= mask_cyc_q + 32'h1;
        end
    end

    // Cycles spent in restart wait, for the length check
    logic [31:0] wait_cyc_q;

    always_ff @(posedge clk) begin
        if (srst || state_q != ST_WAIT) begin
            wait_cyc_q <= '0;
        end else begin
            wait_cyc_q <= wait_cyc_q + 32'h1;
        end
    end

    localparam int MASK_CYC = MASK_TICKS * TICK_CYCLES;
    localparam int WAIT_CYC = WAIT_TICKS * TICK_CYCLES;

    property p_disable_off;
        @(posedge clk) disable iff (srst)
        !en_s |=> !switch_on && !fault_n_oe && state_q == ST_OFF;
    endproperty
    a_disable_off: assert property (p_disable_off)
        else $error("enable low did not force off");

    property p_thermal_now;
        @(posedge clk) disable iff (srst)
        (en_s && hot_s && state_q != ST_LATCHED)
            |=> !switch_on && fault_n_oe;
    endproperty
    a_thermal_now: assert property (p_thermal_now)
        else $error("thermal trip not immediate");

    property p_mask_start;
        @(posedge clk) disable iff (srst)
        (state_q == ST_ON && en_s && !hot_s && ilim_s)
            |=> state_q == ST_MASK && switch_on && !fault_n_oe;
    endproperty
    a_mask_start: assert property (p_mask_start)
        else $error("blanking did not start");

    property p_mask_abort;
        @(posedge clk) disable iff (srst)
        (state_q == ST_MASK && en_s && !hot_s && !ilim_s)
            |=> state_q == ST_ON && switch_on && !fault_n_oe
                && cnt_q == '0;
    endproperty
    a_mask_abort: assert property (p_mask_abort)
        else $error("blanking abort wrong");

    property p_mask_length;
        @(posedge clk) disable iff (srst)
        (state_q == ST_MASK && en_s && !hot_s && ilim_s && state_d != ST_MASK)
            |-> mask_cyc_q == 32'(MASK_CYC - 1);
    endproperty
    a_mask_length: assert property (p_mask_length)
        else $error("blanking interval length wrong");

    property p_mask_quiet;
        @(posedge clk) disable iff (srst)
        state_q == ST_MASK |-> switch_on && !fault_n_oe;
    endproperty
    a_mask_quiet: assert property (p_mask_quiet)
        else $error("flag or switch wrong while blanking");

    property p_wait_length;
        @(posedge clk) disable iff (srst)
        (state_q == ST_WAIT && en_s && !hot_s && state_d != ST_WAIT)
            |-> wait_cyc_q == 32'(WAIT_CYC - 1);
    endproperty
    a_wait_length: assert property (p_wait_length)
        else $error("restart wait length wrong");

    property p_wait_enter;
        @(posedge clk) disable iff (srst)
        (state_q == ST_WAIT && $past(state_q) == ST_MASK)
            |-> AUTORETRY && !switch_on && fault_n_oe;
    endproperty
    a_wait_enter: assert property (p_wait_enter)
        else $error("restart wait entry wrong");

    property p_wait_hold;
        @(posedge clk) disable iff (srst)
        (state_q == ST_WAIT && en_s && !hot_s && !tick)
            |=> state_q == ST_WAIT && !switch_on;
    endproperty
    a_wait_hold: assert property (p_wait_hold)
        else $error("restart wait ended early");

    property p_wait_end;
        @(posedge clk) disable iff (srst)
        (state_q == ST_WAIT && en_s && !hot_s && tick
            && cnt_q == CNT_W'(WAIT_TICKS - 1))
            |=> switch_on && state_q == ST_ON;
    endproperty
    a_wait_end: assert property (p_wait_end)
        else $error("switch not back on after wait");

    property p_retry_clear;
        @(posedge clk) disable iff (srst)
        (state_q == ST_ON && $past(state_q) == ST_WAIT
            && en_s && !hot_s && !ilim_s)
            |=> state_q == ST_ON && !fault_n_oe && switch_on;
    endproperty
    a_retry_clear: assert property (p_retry_clear)
        else $error("fault cleared but flag held");

    property p_latch_hold;
        @(posedge clk) disable iff (srst)
        (en_s && (state_q == ST_LATCHED
            || (!AUTORETRY && state_q == ST_THERMAL)))
            |=> !switch_on && fault_n_oe;
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("latched off state released");

    property p_thermal_back;
        @(posedge clk) disable iff (srst)
        (AUTORETRY && state_q == ST_THERMAL && en_s && !hot_s && cool_s)
            |=> state_q == ST_ON ##1 switch_on || !en_s || hot_s;
    endproperty
    a_thermal_back: assert property (p_thermal_back)
        else $error("no restart after cooling");

    c_blank_abort: cover property (@(posedge clk) disable iff (srst)
        state_q == ST_MASK ##1 state_q == ST_ON);
    c_retry_cycle: cover property (@(posedge clk) disable iff (srst)
        state_q == ST_WAIT ##1 state_q == ST_ON);
    c_latched: cover property (@(posedge clk) disable iff (srst)
        state_q == ST_LATCHED);
    c_thermal: cover property (@(posedge clk) disable iff (srst)
        state_q == ST_THERMAL ##1 state_q == ST_ON);
    c_retry_clear: cover property (@(posedge clk) disable iff (srst)
        state_q == ST_WAIT ##1 state_q == ST_ON ##1 state_q == ST_ON);

endmodule

// *** dv/host_gpio_model.sv ***
// Host GPIO model: drives enable, reads two open-drain fault flags.
// Assumes a pull-up on each flag line and a bench that requests enable.
`timescale 1ns/100ps
module host_gpio_model (
    input  wire logic       clk,
    input  wire logic       en_req,
    input  wire logic [1:0] flag_oe,
    input  wire logic [1:0] flag_o,
    output logic            enable,
    output logic [1:0]      flag_lvl
);
    logic req_q;

    initial enable = 1'b0;
    // Request taken on the rising edge so the bench's falling-edge
    // write cannot race this model; pin moves on the next falling edge
    always @(posedge clk) begin
        req_q <= en_req;
    end
    always @(negedge clk) begin
        enable <= req_q;
    end
    // Released line floats up to the pull-up
    assign flag_lvl[0] = flag_oe[0] ? flag_o[0] : 1'b1;
    assign flag_lvl[1] = flag_oe[1] ? flag_o[1] : 1'b1;
endmodule

// *** dv/test_load_switch_fault_supervisor.sv ***
// Bench: autoretry unit dut and latch-off unit dut_lo on shared pins.
// Assumes a 4-cycle tick, so intervals are 148 and 2220 cycles.
`timescale 1ns/100ps
module test_load_switch_fault_supervisor;
    import lsw_pkg::*;
    logic       clk;
    logic       srst;
    logic       en_req;
    logic       enable;
    logic       fwd;
    logic       rev;
    logic       hot;
    logic       cool;
    logic [1:0] sw;
    logic [1:0] oe;
    logic [1:0] od;
    logic [1:0] lvl;
    sense_s     sns;
    int         fails;
    int         checked;
    int         cyc;

    assign sns = '{enable, fwd, rev, hot, cool};

    load_switch_fault_supervisor #(.TICK_CYCLES(4), .AUTORETRY(1'b1)) dut (
        .clk(clk), .srst(srst), .sense(sns), .switch_on(sw[0]),
        .fault_n_data(od[0]), .fault_n_oe(oe[0]));
    load_switch_fault_supervisor #(.TICK_CYCLES(4), .AUTORETRY(1'b0)) dut_lo (
        .clk(clk), .srst(srst), .sense(sns), .switch_on(sw[1]),
        .fault_n_data(od[1]), .fault_n_oe(oe[1]));
    host_gpio_model host (
        .clk(clk), .en_req(en_req), .flag_oe(oe), .flag_o(od),
        .enable(enable), .flag_lvl(lvl));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Packed as {latch sw, retry sw, latch flag, retry flag}
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: pins %b expected %b", $time, seen, exp);
        end
    endtask

    task automatic final_report();
        if (fails == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 5300 cycles needed
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    task automatic power_up();
        en_req = 1'b1;
        wait_cyc(6);
        check({sw, lvl}, 4'hf);
    endtask

    task automatic short_glitch();
        fwd = 1'b1;
        wait_cyc(140);
        check({sw, lvl}, 4'hf);
        fwd = 1'b0;
        repeat (40) begin
            wait_cyc(1);
            check({sw, lvl}, 4'hf);
        end
    endtask

    // Reverse limit held through two masks, dropped in the second wait
    task automatic persistent();
        rev = 1'b1;
        wait_cyc(143);
        check({sw, lvl}, 4'hf);
        wait_cyc(17);
        check({sw, lvl}, 4'h0);
        wait_cyc(2200);
        check({sw, lvl}, 4'h0);
        wait_cyc(30);
        check({sw, lvl}, 4'h5);
        wait_cyc(150);
        check({sw, lvl}, 4'h0);
        rev = 1'b0;
        wait_cyc(2220);
        check({sw, lvl}, 4'h5);
        wait_cyc(200);
        check({sw, lvl}, 4'h5);
    endtask

    task automatic cycle_enable();
        en_req = 1'b0;
        wait_cyc(6);
        check({sw, lvl}, 4'h3);
        en_req = 1'b1;
        wait_cyc(6);
        check({sw, lvl}, 4'hf);
    endtask

    task automatic thermal();
        hot = 1'b1;
        wait_cyc(4);
        check({sw, lvl}, 4'h0);
        hot = 1'b0;
        cool = 1'b1;
        wait_cyc(6);
        check({sw, lvl}, 4'h5);
        cool = 1'b0;
        wait_cyc(100);
        check({sw, lvl}, 4'h5);
        cycle_enable();
    endtask

    initial begin
        srst = 1'b1;
        en_req = 1'b0;
        fwd = 1'b0;
        rev = 1'b0;
        hot = 1'b0;
        cool = 1'b0;
        wait_cyc(20);
        srst = 1'b0;
        wait_cyc(3);
        power_up();
        short_glitch();
        persistent();
        cycle_enable();
        thermal();
        final_report();
    end
endmodule
